// [sim/msir_host.sv]
// Purpose: host side issuing register requests
// Assumes: request taken at the rising edge
// Notes: released index and data lines show inverted last value, write line held
`timescale 1ns/1ps
`default_nettype none
module msir_host (
  input wire logic clock,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_index,
  output logic [31:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_index = 8'h00;
    req_wdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                      output logic [32:0] q);
    @(negedge clock);
    req_valid = 1'b1;
    req_write = w;
    req_index = i;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'b0;
    req_index = ~i;
    req_wdata = ~d;
    q = {rsp_valid, rsp_rdata};
  endtask
endmodule
`default_nettype wire

// [sim/msir_regs_assertions.sv]
// Purpose: port checks for the status and interrupt register bank
// Assumes: single clock domain, reset active low
// Notes: bound to every msir_regs instance
`timescale 1ns/1ps
`default_nettype none
module msir_regs_chk
  import msir_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic [31:0] req_wdata,
  input wire logic write_allowed,
  input wire logic clear_status,
  input wire logic internal_error,
  input wire logic bad_command,
  input wire logic rsp_valid,
  input wire logic int_pin,
  input wire logic irq_active,
  input wire logic error_any,
  input wire logic stream_en,
  input wire logic [31:0] baud_rate
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence err_pulse;
    internal_error || bad_command;
  endsequence
  sequence wr_ok(logic [7:0] idx);
    req_valid && req_write && write_allowed && req_index == idx;
  endsequence
  rsp_timing_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer one cycle after request");
  rsp_pulse_a: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  err_raise_a: assert property (err_pulse |-> ##2 error_any)
    else $error("error group not raised");
  err_sticky_a: assert property (error_any && !$past(clear_status) |=> error_any)
    else $error("error bit lost without clear");
  pin_gated_a: assert property (int_pin |-> irq_active)
    else $error("pin active without interrupt");
  baud_write_a: assert property (wr_ok(REG_BAUD) |=> baud_rate == $past(req_wdata))
    else $error("link rate not written");
  baud_guard_a: assert property (req_valid && req_write && !write_allowed
    |=> $stable(baud_rate))
    else $error("write taken in wrong state");
  stream_ctl_a: assert property (wr_ok(REG_STREAM) |-> ##2
    stream_en == ($past(req_wdata[7:0], 2) == STREAM_ON))
    else $error("stream control wrong");
endmodule
bind msir_regs msir_regs_chk u_msir_regs_chk (.*);
`default_nettype wire

// [sim/msir_regs_tb_top.sv]
// Purpose: self-checking bench for msir_regs
// Assumes: host model issues the register requests
// Notes: events driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module msir_regs_tb_top import msir_pkg::*;;
  logic clock, rst_b, req_valid, req_write, buf_read_req, clear_status, write_allowed;
  logic svc_created, svc_activated, data_ready, rsp_valid, int_pin, irq_active, error_any;
  logic stream_en;
  logic [4:0] ev;
  logic [7:0] req_index;
  logic [15:0] buf_entries;
  logic [31:0] req_wdata, rsp_rdata, baud_rate, power_mode, exp_s;
  logic [32:0] q;
  int fails, n_compared, cycles;
  wire internal_error, bad_command, bad_mode, create_fail, activate_fail;
  assign {activate_fail, create_fail, bad_mode, bad_command, internal_error} = ev;
  msir_regs #(.IDENT_CODE(16'h3c7e), .VER_MAJOR(8'h02), .VER_MINOR(8'h05),
    .VER_PATCH(8'h09), .MAX_BAUD(32'h000e_1000)) u_msir_regs (.*);
  msir_host u_msir_host (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    u_msir_host.xfer(1'b0, i, 32'h0000_0000, q);
    chk(q, {1'b1, e});
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    u_msir_host.xfer(1'b1, i, d, q);
  endtask
  task automatic strobe(input logic [6:0] v);
    @(negedge clock);
    {buf_read_req, clear_status, ev} = v;
    @(negedge clock);
    {buf_read_req, clear_status, ev} = 7'h00;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_ident();
    chk(baud_rate, BAUD_RESET);
    rd(REG_BAUD, BAUD_RESET);
    wr(REG_IDENT, 32'h0000_0000);
    rd(REG_IDENT, 32'h0000_3c7e);
    rd(REG_VERSION, 32'h0002_0509);
    rd(REG_MAX_BAUD, 32'h000e_1000);
    rd(REG_BUF_LEN, 32'h0000_0123);
    $display("test ident done");
  endtask
  task automatic t_status();
    {svc_created, svc_activated, data_ready} = 3'h7;
    exp_s = 32'h0000_0103;
    rd(REG_STATUS, exp_s);
    for (int k = 0; k < 5; k++) begin
      strobe(7'h01 << k);
      exp_s = exp_s | (32'h0001_0000 << k);
      rd(REG_STATUS, exp_s);
    end
    chk(error_any, 1'b1);
    strobe(7'h20);
    rd(REG_STATUS, 32'h0000_0103);
    chk(error_any, 1'b0);
    rd(8'h3f, 32'h0000_0000);
    rd(REG_STATUS, 32'h0002_0103);
    strobe(7'h20);
    write_allowed = 1'b0;
    wr(REG_BAUD, 32'h0000_4b00);
    rd(REG_BAUD, BAUD_RESET);
    rd(REG_STATUS, 32'h0020_0103);
    strobe(7'h20);
    strobe(7'h40);
    write_allowed = 1'b1;
    rd(REG_STATUS, 32'h0020_0103);
    {svc_created, svc_activated, data_ready} = 3'h0;
    strobe(7'h20);
    rd(REG_STATUS, 32'h0000_0000);
    strobe(7'h21);
    rd(REG_STATUS, 32'h0001_0000);
    $display("test status done");
  endtask
  task automatic t_irq();
    strobe(7'h01);
    wr(REG_INT_MODE, 32'h0000_0001);
    wr(REG_INT_MASK, 32'h0000_0000);
    @(negedge clock);
    chk({irq_active, int_pin}, 2'b00);
    wr(REG_INT_MASK, 32'h0001_0000);
    @(negedge clock);
    chk({irq_active, int_pin}, 2'b11);
    rd(REG_INT_MASK, 32'h0001_0000);
    wr(REG_INT_MODE, 32'h0000_0000);
    @(negedge clock);
    chk({irq_active, int_pin}, 2'b10);
    strobe(7'h20);
    @(negedge clock);
    chk(irq_active, 1'b0);
    $display("test irq done");
  endtask
  task automatic t_write();
    wr(REG_BAUD, 32'h0003_8400);
    chk(baud_rate, 32'h0003_8400);
    wr(REG_POWER, 32'h0000_0002);
    chk(power_mode, 32'h0000_0002);
    for (int v = 0; v < 4; v++) begin
      wr(REG_STREAM, v);
      @(negedge clock);
      chk(stream_en, v == 1);
    end
    $display("test write done");
  endtask
  task automatic t_reset();
    @(negedge clock);
    rst_b = 1'b0;
    @(negedge clock);
    chk({rsp_valid, int_pin, irq_active, error_any, stream_en}, 5'h00);
    chk(baud_rate, BAUD_RESET);
    chk(power_mode, 32'h0000_0000);
    rst_b = 1'b1;
    rd(REG_INT_MASK, 32'h0000_0000);
    rd(REG_INT_MODE, 32'h0000_0000);
    rd(REG_BAUD, BAUD_RESET);
    $display("test reset done");
  endtask
  initial begin
    {rst_b, buf_read_req, clear_status, svc_created, svc_activated, data_ready} = 6'h00;
    write_allowed = 1'b1;
    ev = 5'h00;
    buf_entries = 16'h0123;
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    t_ident();
    t_status();
    t_irq();
    t_write();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire

// [src/msir_irq.sv]
// Purpose: interrupt reduction and pin mode
// Assumes: status and mask from register bank
// Notes: pin active high
`timescale 1ns/1ps
`default_nettype none
module msir_irq
  import msir_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [31:0] status,
  input wire logic [31:0] mask,
  input wire logic [7:0] mode,
  output logic irq_active,
  output logic int_pin
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_active <= 1'b0;
    end else begin
      irq_active <= |(status & mask); // RULE10 RULE18
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_pin <= 1'b0;
    end else begin
      int_pin <= (mode == INT_MODE_ON) && (|(status & mask)); // RULE11
    end
  end
endmodule
`default_nettype wire

// [src/msir_pkg.sv]
// Purpose: constants for the module status and interrupt register bank
// Assumes: register port of 8-bit index, 32-bit data
// Notes: offsets are register indices
package msir_pkg;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_BAUD = 8'h07;
  localparam logic [7:0] REG_INT_MASK = 8'h08;
  localparam logic [7:0] REG_INT_MODE = 8'h09;
  localparam logic [7:0] REG_POWER = 8'h0a;
  localparam logic [7:0] REG_STREAM = 8'h05;
  localparam logic [7:0] REG_IDENT = 8'h10;
  localparam logic [7:0] REG_VERSION = 8'h11;
  localparam logic [7:0] REG_MAX_BAUD = 8'h12;
  localparam logic [7:0] REG_BUF_LEN = 8'he9;
  localparam logic [31:0] CLEARABLE_MASK = 32'hffff_f000;
  localparam logic [31:0] ERROR_MASK = 32'hffff_0000;
  localparam logic [31:0] BAUD_RESET = 32'h0001_c200;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam int BIT_CREATED = 0;
  localparam int BIT_ACTIVATED = 1;
  localparam int BIT_DATA_READY = 8;
  localparam int BIT_ERROR = 16;
  localparam int BIT_BAD_CMD = 17;
  localparam int BIT_BAD_MODE = 18;
  localparam int BIT_CREATE_FAIL = 19;
  localparam int BIT_ACTIVATE_FAIL = 20;
  localparam int BIT_WRONG_STATE = 21;
  localparam logic [7:0] INT_MODE_OFF = 8'h00;
  localparam logic [7:0] INT_MODE_ON = 8'h01;
  localparam logic [7:0] STREAM_ON = 8'h01;
  typedef enum logic [1:0] {MSIR_IDLE, MSIR_ANSWER} msir_state_e;
endpackage

// [src/msir_regs.sv]
// Purpose: general register bank of a sensor module
// Assumes: protocol engine presents decoded register requests
// Notes: reads answer one cycle after the request
//
// Notes on behaviour
// (RULE1) status bit 0 set when service or detector created
// (RULE2) status bit 1 set when service or detector activated
// (RULE3) status bit 8 set when result data waits in output buffer
// (RULE4) status bit 16 set on general internal error
// (RULE5) bit 17 on bad command or parameter, bit 18 on invalid mode
// (RULE6) bit 19 on create failure, bit 20 on activate failure
// (RULE7) bit 21 on write or buffer read in wrong state
// (RULE8) clear-status clears only clearable group, low bits kept
// (RULE9) upper sixteen status bits form the error group
// (RULE10) interrupt when a status bit and its mask bit are both set
// (RULE11) mode 0 holds pin inactive, mode 1 pin follows interrupt
// (RULE12) link rate register selects baud rate, resets to 115200
// (RULE13) read-only register holds highest supported baud rate
// (RULE14) version word: major 23:16, minor 15:8, patch 7:0
// (RULE15) read-only count of valid entries in output buffer
// (RULE16) stream results only while streaming control equals 1
// (RULE17) read-only 16-bit identification code of module variant
// (RULE18) interrupt is OR of status AND mask, every cycle
`timescale 1ns/1ps
`default_nettype none
module msir_regs
  import msir_pkg::*;
#(
  parameter logic [15:0] IDENT_CODE = 16'h5a01, // arbitrary value
  parameter logic [7:0] VER_MAJOR = 8'h01,
  parameter logic [7:0] VER_MINOR = 8'h00,
  parameter logic [7:0] VER_PATCH = 8'h00,
  parameter logic [31:0] MAX_BAUD = 32'h001e_8480
)(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic [31:0] req_wdata,
  input wire logic buf_read_req,
  input wire logic clear_status,
  input wire logic write_allowed,
  input wire logic svc_created,
  input wire logic svc_activated,
  input wire logic data_ready,
  input wire logic internal_error,
  input wire logic bad_command,
  input wire logic bad_mode,
  input wire logic create_fail,
  input wire logic activate_fail,
  input wire logic [15:0] buf_entries,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic int_pin,
  output logic irq_active,
  output logic error_any,
  output logic stream_en,
  output logic [31:0] baud_rate,
  output logic [31:0] power_mode
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [31:0] mask_ff;
  logic [7:0] int_mode_ff;
  logic [7:0] stream_ff;
  logic [31:0] status;
  logic [31:0] set_bits;
  logic [31:0] level_bits;
  logic wr_hit;
  logic bad_index;

  function automatic logic index_known(input logic [7:0] idx);
    unique case (idx)
      REG_STATUS, REG_BAUD, REG_INT_MASK, REG_INT_MODE, REG_POWER, REG_STREAM,
      REG_IDENT, REG_VERSION, REG_MAX_BAUD, REG_BUF_LEN: index_known = 1'b1;
      default: index_known = 1'b0;
    endcase
  endfunction

  assign wr_hit = req_valid && req_write && write_allowed;
  assign bad_index = req_valid && !index_known(req_index);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_ff <= ZERO32;
    end else if (wr_hit && req_index == REG_INT_MASK) begin
      mask_ff <= req_wdata;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_mode_ff <= INT_MODE_OFF;
    end else if (wr_hit && req_index == REG_INT_MODE) begin
      int_mode_ff <= req_wdata[7:0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      baud_rate <= BAUD_RESET; // RULE12
    end else if (wr_hit && req_index == REG_BAUD) begin
      baud_rate <= req_wdata; // RULE12
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_mode <= ZERO32;
    end else if (wr_hit && req_index == REG_POWER) begin
      power_mode <= req_wdata;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stream_ff <= ZERO32[7:0];
    end else if (wr_hit && req_index == REG_STREAM) begin
      stream_ff <= req_wdata[7:0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stream_en <= 1'b0;
    end else begin
      stream_en <= (stream_ff == STREAM_ON); // RULE16
    end
  end

  // ----------------------------------------------------------------
  // status events
  // ----------------------------------------------------------------
  always_comb begin
    set_bits = ZERO32;
    level_bits = ZERO32;
    level_bits[BIT_CREATED] = svc_created; // RULE1
    level_bits[BIT_ACTIVATED] = svc_activated; // RULE2
    level_bits[BIT_DATA_READY] = data_ready; // RULE3
    set_bits[BIT_ERROR] = internal_error; // RULE4
    set_bits[BIT_BAD_CMD] = bad_command || bad_index; // RULE5
    set_bits[BIT_BAD_MODE] = bad_mode; // RULE5
    set_bits[BIT_CREATE_FAIL] = create_fail; // RULE6
    set_bits[BIT_ACTIVATE_FAIL] = activate_fail; // RULE6
    set_bits[BIT_WRONG_STATE] = ((req_valid && req_write) || buf_read_req)
                                && !write_allowed; // RULE7
  end

  msir_status u_status (
    .clock(clock),
    .rst_b(rst_b),
    .set_bits(set_bits),
    .level_bits(level_bits),
    .clear_req(clear_status),
    .status(status)
  );

  msir_irq u_irq (
    .clock(clock),
    .rst_b(rst_b),
    .status(status),
    .mask(mask_ff),
    .mode(int_mode_ff),
    .irq_active(irq_active),
    .int_pin(int_pin)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      error_any <= 1'b0;
    end else begin
      error_any <= |(status & ERROR_MASK); // RULE9
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rsp_rdata <= ZERO32;
    end else if (req_valid) begin
      unique case (req_index)
        REG_STATUS: rsp_rdata <= status;
        REG_BAUD: rsp_rdata <= baud_rate;
        REG_INT_MASK: rsp_rdata <= mask_ff;
        REG_INT_MODE: rsp_rdata <= {24'h00_0000, int_mode_ff};
        REG_POWER: rsp_rdata <= power_mode;
        REG_STREAM: rsp_rdata <= {24'h00_0000, stream_ff};
        REG_IDENT: rsp_rdata <= {16'h0000, IDENT_CODE}; // RULE17
        REG_VERSION: rsp_rdata <= {8'h00, VER_MAJOR, VER_MINOR, VER_PATCH}; // RULE14
        REG_MAX_BAUD: rsp_rdata <= MAX_BAUD; // RULE13
        REG_BUF_LEN: rsp_rdata <= {16'h0000, buf_entries}; // RULE15
        default: rsp_rdata <= ZERO32;
      endcase
    end
  end
endmodule
`default_nettype wire

// [src/msir_status.sv]
// Purpose: sticky module status word
// Assumes: event inputs are one-cycle pulses or levels
// Notes: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module msir_status
  import msir_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [31:0] set_bits,
  input wire logic [31:0] level_bits,
  input wire logic clear_req,
  output logic [31:0] status
);
  logic [31:0] sticky_ff;
  logic [31:0] nxt_sticky;
  always_comb begin
    nxt_sticky = sticky_ff;
    if (clear_req) begin
      nxt_sticky = sticky_ff & ~CLEARABLE_MASK; // RULE8
    end
    nxt_sticky = nxt_sticky | set_bits;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sticky_ff <= ZERO32;
    end else begin
      sticky_ff <= nxt_sticky;
    end
  end
  // low group follows live state, never cleared by command
  assign status = (sticky_ff & CLEARABLE_MASK) | (level_bits & ~CLEARABLE_MASK); // RULE8
endmodule
`default_nettype wire
